// ---- sim/gsp_dev_model.sv ----
// Purpose: Gyro SPI slave model
// Assumes: Host holds sclk low outside frames
// Notes: Only 07h and 08h exist
`timescale 1ns/100ps
module gsp_dev_model (
   input  wire logic        cs_n,
   input  wire logic        sclk,
   input  wire logic        mosi,
   input  wire logic        rst_n,
   input  wire logic [15:0] mon,
   input  wire logic        bad_par,
   output logic             miso
);
   logic [15:0] ctrl = 16'h0000;
   logic        pok  = 1'b1;
   logic        ps, bad, bad_a, pw;
   logic [16:0] rx, sh;
   logic [15:0] w;
   logic [6:0]  wa;
   int          cnt, nb;
   function automatic logic [15:0] val(input logic [6:0] a);
      return (a == 7'h07) ? ctrl : (a == 7'h08) ? {mon[15:10], pok, mon[8:0]} : 16'h0000;
   endfunction : val
   function automatic logic [16:0] enc(input logic [15:0] v);
      logic [15:0] x;
      x = {v[14:0], ~^v[14:0]};
      return {x, ps ^ (^x) ^ bad_par};
   endfunction : enc
   function automatic logic [16:0] stw();
      logic [15:0] s;
      s = val(7'h08);
      return enc({15'h0000, &s[15:2]});
   endfunction : stw
   always @(negedge rst_n) begin
      ctrl = 16'h0000;
      pok = 1'b1;
   end
   always @(negedge cs_n) begin
      cnt = 0;
      pw = 1'b0;
      nb = ctrl[12] ? 17 : 16;
      ps = ctrl[13];
      sh = stw();
      miso = sh[16];
      sh = sh << 1;
   end
   // Released line shows the inverse of its last bit
   always @(posedge cs_n) miso = ~miso;
   always @(negedge sclk) if (!cs_n) begin
      miso = sh[16];
      sh = sh << 1;
   end
   always @(posedge sclk) if (!cs_n) begin
      rx = {rx[15:0], mosi};
      cnt++;
      if (cnt == nb) begin
         cnt = 0;
         w = (nb == 17) ? rx[16:1] : rx[15:0];
         bad = (nb == 17) && ((^rx) != ps);
         if (bad) pok = 1'b0;
         if (pw) begin
            if (!bad && !bad_a && wa == 7'h07) ctrl = w[3] ? 16'h0000 : {1'b0, w[15:1]};
            sh = stw();
            pw = 1'b0;
         end else begin
            sh = enc(val(w[9:3]));
            if (w[9:3] == 7'h08 && !w[2]) pok = 1'b1;
            pw = w[2];
            wa = w[9:3];
            bad_a = bad;
         end
      end
   end
endmodule : gsp_dev_model

// ---- sim/gsp_host_tb.sv ----
// Purpose: Self-checking bench for gsp_host
// Assumes: Short power-up count
// Notes: Bench model tracks sensor registers
`timescale 1ns/100ps
module gsp_host_tb;
   import gsp_pkg::*;
   logic        aclk = 0, aresetn = 0, bad_par = 0;
   logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic        s_axi_arvalid = 0, s_axi_rready = 0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, dv;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
   logic [15:0] mon = 16'hFFFF;
   logic        chip_select_n, sclk, mosi, miso, ext_reset_n;
   int          miscompares = 0, n_tests = 0, cyc = 0, b_ctrl = 0, n;
   gsp_host #(.PWRUP_CYCLES(50), .SCK_HALF(4)) gsp_host_i (.aclk, .aresetn,
      .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
      .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
      .s_axi_rdata, .s_axi_rresp, .chip_select_n, .sclk, .mosi, .miso, .ext_reset_n);
   gsp_dev_model gsp_dev_model_i (.cs_n(chip_select_n), .sclk(sclk), .mosi(mosi),
      .rst_n(ext_reset_n), .mon(mon), .bad_par(bad_par), .miso(miso));
   always #20 aclk = ~aclk;
   task close_out;
      $display("comparisons %0d miscompares %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : close_out
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 60000) begin
         miscompares++;
         close_out;
      end
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         miscompares++;
         $display("unexpected at %0t: got %h want %h", $time, g, e);
      end
   endtask : chk
   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wready) s_axi_wvalid <= 0;
      end while (!s_axi_bvalid);
      rs = s_axi_bresp;
      s_axi_bready <= 0;
   endtask : axw
   task automatic axr(input logic [7:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 0;
      end while (!s_axi_rvalid);
      dv = s_axi_rdata;
      rs = s_axi_rresp;
      s_axi_rready <= 0;
   endtask : axr
   task automatic cmd(input int a, input int rw, input int d);
      logic [15:0] s;
      int          v;
      axw(REG_CMD, {9'h000, d[14:0], rw[0], a[6:0]});
      chk(rs, RESP_OKAY);
      // Monitor flags driven just before the call have settled by now
      s = mon | 16'h0200;
      v = (a == 7) ? b_ctrl : (a == 8) ? s : 0;
      n = 0;
      do begin
         axr(REG_STAT);
         n++;
      end while (dv[STAT_DONE_BIT] !== 1'b1 && n < 500);
      chk(dv[STAT_DONE_BIT], 1'b1);
      axw(REG_STAT, 32'h2);
      axr(REG_RESULT);
      chk(dv, v & 32'h7FFF);
      axr(REG_FLAGS);
      chk(dv, {&s[15:2], ~&s[15:2]});
      if (rw == 1 && a == 7) b_ctrl = d[2] ? 0 : d;
   endtask : cmd
   initial begin
      void'($urandom(32'h19b0e01b));
      repeat (10) @(posedge aclk);
      aresetn <= 1;
      n = 0;
      do begin
         axr(REG_STAT);
         n++;
      end while (dv[STAT_INIT_BIT] !== 1'b1 && n < 500);
      chk(dv[STAT_INIT_BIT], 1'b1);
      // Power-up frames leave done set; clear it before the first command
      axw(REG_STAT, 32'h2);
      chk(ext_reset_n, 1'b1);
      axr(8'h14);
      chk(rs, RESP_SLVERR);
      axw(REG_RESULT, 32'h0);
      chk(rs, RESP_SLVERR);
      for (int i = 0; i < 6; i++) begin
         mon <= $urandom_range(0, 1) ? 16'hFFFF : 16'($urandom);
         cmd($urandom_range(0, 127), 0, 0);
      end
      cmd(8, 0, 0);
      cmd(7, 1, ($urandom & 32'h2FF3) | 32'h1000);
      axr(REG_CTRL);
      chk(dv[1:0], {b_ctrl[13], b_ctrl[12]});
      cmd(8, 0, 0);
      cmd(3, 1, 5);
      bad_par <= 1;
      cmd(7, 0, 0);
      bad_par <= 0;
      axr(REG_STAT);
      chk(dv[STAT_PERR_BIT], 1'b1);
      axw(REG_STAT, 32'h10);
      axr(REG_STAT);
      chk(dv[STAT_PERR_BIT], 1'b0);
      cmd(7, 1, 4);
      axr(REG_CTRL);
      chk(dv, 0);
      axw(REG_CTRL, 32'h4);
      // Pin follows one cycle after the write answer
      @(posedge aclk);
      chk(ext_reset_n, 1'b0);
      axw(REG_CMD, 32'h8);
      chk(rs, RESP_SLVERR);
      axw(REG_CTRL, 32'h0);
      b_ctrl = 0;
      cmd(7, 0, 0);
      close_out;
   end
endmodule : gsp_host_tb

// ---- verilog/gsp_host.sv ----
// Purpose: SPI host for the gyro sensor with AXI4-Lite registers
// Assumes: 25 MHz aclk; sensor slave on four wires
// Notes: One command per frame; power-up reads run by themselves
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/100ps
module gsp_host
   import gsp_pkg::*;
#(
   parameter int PWRUP_CYCLES = PWRUP_CYC,
   parameter int SCK_HALF     = SCK_HALF_CYC
)(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   output logic [1:0]       s_axi_bresp,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   input  wire logic [7:0]  s_axi_araddr,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             chip_select_n,
   output logic             sclk,
   output logic             mosi,
   input  wire logic        miso,
   output logic             ext_reset_n
);
   ////////////////////////////////////////////////////////////////////////////
   gsp_state_type st_q;
   logic [31:0]   tmr_q;
   logic [1:0]    wptr_q;
   logic [1:0]    last_w;
   logic [6:0]    cmd_addr_q;
   logic          cmd_rw_q;
   logic [14:0]   cmd_data_q;
   logic          init_left_q;
   logic          init_done_q;
   logic          start_q;
   logic [15:0]   tx_q;
   logic          pbit_q;
   logic [15:0]   tx_next;
   logic          par_en_q;
   logic          psel_q;
   logic          rst_pin_q;
   logic          word_done;
   logic [16:0]   rx_word;
   logic [15:0]   rx16;
   logic          rx_bad;
   logic          done_q;
   logic          done_set;
   logic          perr_q;
   logic          sok_q;
   logic [15:0]   flags_q;
   logic [14:0]   result_q;
   logic          aw_full_q;
   logic          w_full_q;
   logic [7:0]    awaddr_q;
   logic [31:0]   wdata_q;
   logic          wstrb0_q;
   logic          wr_fire;
   logic          wr_ok;
   logic          cmd_go;
   logic          stat_w1c;
   logic [31:0]   rd_data;
   logic          rd_ok;

   function automatic logic [15:0] gsp_odd_word(input logic [14:0] b);
      return {b, ~^b};
   endfunction : gsp_odd_word

   function automatic logic gsp_par_bit(input logic [15:0] w, input logic sel);
      return (^w) ^ sel;
   endfunction : gsp_par_bit

   ////////////////////////////////////////////////////////////////////////////
   // Word schedule: address, then data or zero, then zero after a write

   assign last_w = cmd_rw_q ? 2'h2 : 2'h1;

   always_comb begin
      case (wptr_q)
         2'h0:    tx_next = gsp_odd_word({6'h00, cmd_addr_q, cmd_rw_q, 1'b0});
         2'h1:    tx_next = cmd_rw_q ? gsp_odd_word(cmd_data_q) : 16'h0000;
         default: tx_next = 16'h0000;
      endcase
   end

   assign cmd_go = wr_fire && awaddr_q == REG_CMD && wstrb0_q && st_q == ST_IDLE
                   && !rst_pin_q;

   assign done_set = st_q == ST_GAP && tmr_q == 32'(2 * SCK_HALF - 1) && !init_left_q;

   ////////////////////////////////////////////////////////////////////////////
   // Frame sequencer

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_q        <= ST_PWR;
         tmr_q       <= 32'h0000_0000;
         wptr_q      <= 2'h0;
         cmd_addr_q  <= 7'h00;
         cmd_rw_q    <= 1'b0;
         cmd_data_q  <= 15'h0000;
         init_left_q <= 1'b0;
         init_done_q <= 1'b0;
         chip_select_n <= 1'b1;
         start_q     <= 1'b0;
         tx_q        <= 16'h0000;
         pbit_q      <= 1'b0;
         par_en_q    <= 1'b0;
         psel_q      <= 1'b0;
      end else begin
         start_q <= 1'b0;
         if (rst_pin_q) begin
            par_en_q <= 1'b0;
            psel_q   <= 1'b0;
         end
         case (st_q)
            ST_PWR: begin
               if (tmr_q == 32'(PWRUP_CYCLES - 1)) begin
                  // Two status reads acknowledge start-up flags
                  cmd_addr_q    <= DEV_STAT_ADDR;
                  cmd_rw_q      <= 1'b0;
                  init_left_q   <= 1'b1;
                  wptr_q        <= 2'h0;
                  tmr_q         <= 32'h0000_0000;
                  chip_select_n <= 1'b0;
                  st_q          <= ST_SETUP;
               end else begin
                  tmr_q <= tmr_q + 32'h0000_0001;
               end
            end
            ST_IDLE: begin
               if (cmd_go) begin
                  cmd_addr_q    <= wdata_q[6:0];
                  cmd_rw_q      <= wdata_q[CMD_RW_BIT];
                  cmd_data_q    <= wdata_q[CMD_DATA_LSB +: 15];
                  wptr_q        <= 2'h0;
                  tmr_q         <= 32'h0000_0000;
                  chip_select_n <= 1'b0;
                  st_q          <= ST_SETUP;
               end
            end
            ST_SETUP: begin
               if (tmr_q == 32'(SCK_HALF - 1)) begin
                  start_q <= 1'b1;
                  tx_q    <= tx_next;
                  pbit_q  <= gsp_par_bit(tx_next, psel_q);
                  st_q    <= ST_WORD;
               end else begin
                  tmr_q <= tmr_q + 32'h0000_0001;
               end
            end
            ST_WORD: begin
               if (word_done) begin
                  tmr_q <= 32'h0000_0000;
                  if (wptr_q == last_w) begin
                     st_q <= ST_HOLD;
                  end else begin
                     wptr_q <= wptr_q + 2'h1;
                     st_q   <= ST_SETUP;
                  end
               end
            end
            ST_HOLD: begin
               if (tmr_q == 32'(SCK_HALF - 1)) begin
                  chip_select_n <= 1'b1;
                  tmr_q         <= 32'h0000_0000;
                  st_q          <= ST_GAP;
                  if (cmd_rw_q && cmd_addr_q == DEV_CTRL_ADDR && !rst_pin_q) begin
                     // Follow the sensor's parity mode after it takes it
                     par_en_q <= cmd_data_q[DEV_PEN_BIT];
                     psel_q   <= cmd_data_q[DEV_PSEL_BIT];
                  end
               end else begin
                  tmr_q <= tmr_q + 32'h0000_0001;
               end
            end
            ST_GAP: begin
               if (tmr_q == 32'(2 * SCK_HALF - 1)) begin
                  tmr_q <= 32'h0000_0000;
                  if (init_left_q) begin
                     init_left_q   <= 1'b0;
                     wptr_q        <= 2'h0;
                     chip_select_n <= 1'b0;
                     st_q          <= ST_SETUP;
                  end else begin
                     init_done_q <= 1'b1;
                     st_q        <= ST_IDLE;
                  end
               end else begin
                  tmr_q <= tmr_q + 32'h0000_0001;
               end
            end
            default: st_q <= ST_IDLE;
         endcase
      end
   end

   gsp_spi_word #(
      .HALF (SCK_HALF)
   ) u_word (
      .aclk    (aclk),
      .aresetn (aresetn),
      .start   (start_q),
      .par_en  (par_en_q),
      .tx_word (tx_q),
      .tx_pbit (pbit_q),
      .miso    (miso),
      .sclk    (sclk),
      .mosi    (mosi),
      .done    (word_done),
      .rx_word (rx_word)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Answers: status on first word and after write data, result otherwise

   assign rx16   = par_en_q ? rx_word[16:1] : rx_word[15:0];
   // All-zero answers come from missing registers and carry no parity
   assign rx_bad = (rx16 != 16'h0000 && !(^rx16))
                   || (par_en_q && (^{rx16, rx_word[0]}) != psel_q);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flags_q  <= 16'h0000;
         sok_q    <= 1'b0;
         result_q <= 15'h0000;
      end else if (word_done) begin
         if (wptr_q == 2'h1) begin
            result_q <= rx16[15:1];
         end else begin
            flags_q <= rx16;
            sok_q   <= rx16[SOK_BIT];
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         done_q <= 1'b0;
         perr_q <= 1'b0;
      end else begin
         done_q <= done_set || (done_q && !(stat_w1c && wdata_q[STAT_DONE_BIT]));
         perr_q <= (word_done && rx_bad)
                   || (perr_q && !(stat_w1c && wdata_q[STAT_PERR_BIT]));
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite write channel

   assign wr_fire  = aw_full_q && w_full_q && !s_axi_bvalid;
   assign stat_w1c = wr_fire && awaddr_q == REG_STAT && wstrb0_q;
   assign wr_ok    = awaddr_q == REG_CTRL || awaddr_q == REG_STAT
                     || (awaddr_q == REG_CMD && cmd_go);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
         aw_full_q     <= 1'b0;
         w_full_q      <= 1'b0;
         awaddr_q      <= 8'h00;
         wdata_q       <= 32'h0000_0000;
         wstrb0_q      <= 1'b0;
         rst_pin_q     <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awaddr_q      <= s_axi_awaddr;
            aw_full_q     <= 1'b1;
            s_axi_awready <= 1'b0;
         end else if (!aw_full_q && !s_axi_bvalid) begin
            s_axi_awready <= 1'b1;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wdata_q      <= s_axi_wdata;
            wstrb0_q     <= s_axi_wstrb[0];
            w_full_q     <= 1'b1;
            s_axi_wready <= 1'b0;
         end else if (!w_full_q && !s_axi_bvalid) begin
            s_axi_wready <= 1'b1;
         end
         if (wr_fire) begin
            aw_full_q    <= 1'b0;
            w_full_q     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            if (awaddr_q == REG_CTRL && wstrb0_q) begin
               rst_pin_q <= wdata_q[CTRL_RST_BIT];
            end
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ext_reset_n <= 1'b0;
      end else begin
         ext_reset_n <= !rst_pin_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite read channel

   always_comb begin
      rd_data = 32'h0000_0000;
      rd_ok   = 1'b1;
      case (s_axi_araddr)
         REG_CTRL: begin
            rd_data[CTRL_PEN_BIT]  = par_en_q;
            rd_data[CTRL_PSEL_BIT] = psel_q;
            rd_data[CTRL_RST_BIT]  = rst_pin_q;
         end
         REG_CMD:    rd_data = {9'h000, cmd_data_q, cmd_rw_q, cmd_addr_q};
         REG_STAT: begin
            rd_data[STAT_BUSY_BIT] = st_q != ST_IDLE;
            rd_data[STAT_DONE_BIT] = done_q;
            rd_data[STAT_INIT_BIT] = init_done_q;
            rd_data[STAT_SOK_BIT]  = sok_q;
            rd_data[STAT_PERR_BIT] = perr_q;
         end
         REG_RESULT: rd_data = {17'h00000, result_q};
         REG_FLAGS:  rd_data = {16'h0000, flags_q};
         default:    rd_ok = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= rd_data;
         s_axi_rresp   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end else if (!s_axi_rvalid) begin
         s_axi_arready <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   chk_cs_word_low: assert property (st_q == ST_WORD |-> !chip_select_n)
      else $error("chip select high inside a word");
   chk_cs_frame_end: assert property ($rose(chip_select_n) |-> $past(st_q) == ST_HOLD)
      else $error("chip select rose outside frame end");
   chk_addr_layout: assert property (start_q && wptr_q == 2'h0
      |-> tx_q[15:10] == 6'h00 && !tx_q[1])
      else $error("address word layout wrong");
   chk_rw_bit: assert property (start_q && wptr_q == 2'h0 |-> tx_q[2] == cmd_rw_q)
      else $error("access bit does not match command");
   chk_odd_parity: assert property (start_q && tx_q != 16'h0000 |-> ^tx_q)
      else $error("sent word parity not odd");
   chk_zero_tail: assert property (start_q && wptr_q == last_w |-> tx_q == 16'h0000)
      else $error("last word of frame not zero");
   chk_extra_pbit: assert property (start_q |-> (^{tx_q, pbit_q}) == psel_q)
      else $error("appended parity bit wrong");
   chk_init_status: assert property (start_q && !init_done_q && wptr_q == 2'h0
      |-> tx_q[9:3] == DEV_STAT_ADDR && !tx_q[2])
      else $error("start-up read not aimed at status");
   chk_word_follows: assert property (start_q |-> ##[1:200] word_done)
      else $error("word never completed");
   chk_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write answer dropped early");

   cov_read_cmd: cover property (done_set && !cmd_rw_q);
   cov_write_cmd: cover property (done_set && cmd_rw_q);
   cov_parity_frame: cover property (start_q && par_en_q);
   cov_rx_error: cover property (word_done && rx_bad);
endmodule : gsp_host

// ---- verilog/gsp_pkg.sv ----
// Purpose: Constants and types for the gyro SPI host controller
// Assumes: 25 MHz aclk, AXI4-Lite register port, 32-bit data
// Notes: Host drives the sensor's four-wire port as SPI master
// Operation
// - Words 16 bits; change falling, sample rising
// - First word: address, RW, parity layout
// - RW one writes, zero reads
// - D0 makes odd count of ones
// - Write data in D15..D1, parity D0
// - Chip select low across whole frame
// - Extra zero word collects last read
// - Parity mode adds seventeenth clock per word
// - Both ends append and check parity bit
// - After power-up wait, read status twice
package gsp_pkg;
   localparam int CLK_PERIOD_NS     = 40;
   localparam int SPI_MIN_PERIOD_NS = 125;
   localparam int SCK_HALF_MIN_CYC  =
      (SPI_MIN_PERIOD_NS + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);
   // Doubled so the two-flop data-in path still samples mid-bit
   localparam int SCK_HALF_CYC      = 2 * SCK_HALF_MIN_CYC;
   localparam int PWRUP_MS          = 800;
   localparam int PWRUP_CYC         = PWRUP_MS * 1000000 / CLK_PERIOD_NS;

   localparam logic [4:0] WORD_BITS = 5'h10;
   localparam logic [4:0] PAR_BITS  = 5'h11;

   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_CMD    = 8'h04;
   localparam logic [7:0] REG_STAT   = 8'h08;
   localparam logic [7:0] REG_RESULT = 8'h0C;
   localparam logic [7:0] REG_FLAGS  = 8'h10;

   localparam int CTRL_PEN_BIT  = 0;
   localparam int CTRL_PSEL_BIT = 1;
   localparam int CTRL_RST_BIT  = 2;
   localparam int CMD_RW_BIT    = 7;
   localparam int CMD_DATA_LSB  = 8;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_DONE_BIT = 1;
   localparam int STAT_INIT_BIT = 2;
   localparam int STAT_SOK_BIT  = 3;
   localparam int STAT_PERR_BIT = 4;

   localparam logic [6:0] DEV_CTRL_ADDR = 7'h07;
   localparam logic [6:0] DEV_STAT_ADDR = 7'h08;
   localparam int         DEV_PEN_BIT   = 12;
   localparam int         DEV_PSEL_BIT  = 13;
   localparam int         SOK_BIT       = 1;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [5:0] {
      ST_IDLE  = 6'h01,
      ST_PWR   = 6'h02,
      ST_SETUP = 6'h04,
      ST_WORD  = 6'h08,
      ST_HOLD  = 6'h10,
      ST_GAP   = 6'h20
   } gsp_state_type;
endpackage : gsp_pkg

// ---- verilog/gsp_spi_word.sv ----
// Purpose: Shifts one SPI word out and in, 16 or 17 clocks
// Assumes: Clock idles low; caller holds chip select
// Notes: Data-in passes two flops before it is sampled
`timescale 1ns/100ps
module gsp_spi_word
   import gsp_pkg::*;
#(
   parameter int HALF = SCK_HALF_CYC
)(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        start,
   input  wire logic        par_en,
   input  wire logic [15:0] tx_word,
   input  wire logic        tx_pbit,
   input  wire logic        miso,
   output logic             sclk,
   output logic             mosi,
   output logic             done,
   output logic [16:0]      rx_word
);
   logic        miso_m_q;
   logic        miso_s_q;
   logic [16:0] sh_q;
   logic [4:0]  bit_q;
   logic [7:0]  ph_q;
   logic        act_q;
   logic [4:0]  nbits;
   logic [4:0]  rise_cnt_q;

   assign nbits = par_en ? PAR_BITS : WORD_BITS;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         miso_m_q <= 1'b0;
         miso_s_q <= 1'b0;
      end else begin
         miso_m_q <= miso;
         miso_s_q <= miso_m_q;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         act_q   <= 1'b0;
         sclk    <= 1'b0;
         mosi    <= 1'b0;
         done    <= 1'b0;
         bit_q   <= 5'h00;
         ph_q    <= 8'h00;
         sh_q    <= 17'h00000;
         rx_word <= 17'h00000;
      end else begin
         done <= 1'b0;
         if (!act_q && start) begin
            act_q   <= 1'b1;
            sh_q    <= {tx_word, tx_pbit};
            mosi    <= tx_word[15];
            bit_q   <= 5'h00;
            ph_q    <= 8'h00;
            rx_word <= 17'h00000;
         end else if (act_q) begin
            if (ph_q == 8'(HALF - 1)) begin
               ph_q <= 8'h00;
               if (!sclk) begin
                  sclk <= 1'b1;
               end else begin
                  // Falling edge: capture, then present next bit
                  sclk    <= 1'b0;
                  rx_word <= {rx_word[15:0], miso_s_q};
                  sh_q    <= {sh_q[15:0], 1'b0};
                  mosi    <= sh_q[15];
                  bit_q   <= bit_q + 5'h01;
                  if (bit_q == nbits - 5'h01) begin
                     act_q <= 1'b0;
                     done  <= 1'b1;
                  end
               end
            end else begin
               ph_q <= ph_q + 8'h01;
            end
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rise_cnt_q <= 5'h00;
      end else if (start && !act_q) begin
         rise_cnt_q <= 5'h00;
      end else if (act_q && !sclk && ph_q == 8'(HALF - 1)) begin
         rise_cnt_q <= rise_cnt_q + 5'h01;
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   chk_word_len: assert property (done |-> rise_cnt_q == nbits)
      else $error("word clock count wrong");
   chk_mosi_hold: assert property (sclk && $past(sclk) |-> $stable(mosi))
      else $error("mosi moved while clock high");
endmodule : gsp_spi_word
